// [hdl/iph_map.svh]
`ifndef IPH_MAP_SVH
`define IPH_MAP_SVH

// ----------------------------------------------------------------
// Command addressing
// ----------------------------------------------------------------
`define IPH_DEST_IMAGE 8'h04
`define IPH_OP_DRIVE 8'h8C
`define IPH_OP_ALG 8'h40
`define IPH_OP_BRIGHT 8'h41
`define IPH_OP_CONTRAST 8'h42

// ----------------------------------------------------------------
// Parameter lengths in bytes
// ----------------------------------------------------------------
`define IPH_LEN_DRIVE_WR 4'hD
`define IPH_LEN_DRIVE_RD 4'h1
`define IPH_LEN_DRIVE_RSP 4'hC
`define IPH_LEN_ALG 4'h7
`define IPH_LEN_WORD 4'h2
`define IPH_LEN_NONE 4'h0
`define IPH_LEN_BAD 4'hF
`define IPH_BUF_DEPTH 4'hD

// ----------------------------------------------------------------
// Ranges, reset values and algorithm flag bits
// ----------------------------------------------------------------
`define IPH_BRIGHT_MIN 16'hFC00
`define IPH_BRIGHT_MAX 16'h03FF
`define IPH_CONTRAST_MAX 16'h00C8
`define IPH_CONTRAST_DEF 8'h64
`define IPH_ALG_CHROMA 3'h0
`define IPH_ALG_DEGAMMA 3'h1
`define IPH_ALG_CCA 3'h2
`define IPH_ALG_MULTI 3'h3
`define IPH_ALG_WHITE 3'h4
`define IPH_ALG_BLACK 3'h5
`define IPH_ALG_HDR 3'h6

// ----------------------------------------------------------------
// Datapath constants
// ----------------------------------------------------------------
`define IPH_PAD_ZERO 2'h0
`define IPH_RECIP_100 32'h0000051F
`define IPH_MATRIX_ONE 12'h400
`define IPH_MATRIX_FRAC 10
`define IPH_PIX_MAX 12'hFFF
`define IPH_CHROMA_CORE 13'sh0004
`define IPH_CHROMA_LIMIT 13'sh0040
`define IPH_CHROMA_MAX 13'sh03FF
`define IPH_THIRD_MUL 17'h00055
`define IPH_THIRD_SHIFT 8

`endif

// [hdl/iph_pkg.sv]
package iph_pkg;
    typedef enum logic [1:0] {
        IPH_IDLE = 2'b00,
        IPH_COLLECT = 2'b01,
        IPH_RESPOND = 2'b10
    } iph_state_e;
    typedef logic [7:0] iph_byte_t;
    typedef logic [11:0] iph_pix_t;
endpackage

// [hdl/iph_pixel_path.sv]
`timescale 1ns/1ps
`include "iph_map.svh"

module iph_pixel_path
    import iph_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic pixValid,
    input wire logic [9:0] pixInRed,
    input wire logic [9:0] pixInGreen,
    input wire logic [9:0] pixInBlue,
    input wire logic chromaEn,
    input wire logic chromaFreqSel,
    input wire logic degammaEn,
    input wire logic ccaEn,
    input wire logic multiEn,
    input wire logic [10:0] brightBias,
    input wire logic [8:0] contrastPct,
    input wire logic [107:0] matrixCoef,
    output logic pixOutValid,
    output iph_pix_t pixOutRed,
    output iph_pix_t pixOutGreen,
    output iph_pix_t pixOutBlue,
    output iph_pix_t pixOutYellow,
    output iph_pix_t pixOutCyan
);

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Square law stands in for the decode curve; float is {mant,exp}
    function automatic iph_pix_t degamma(input logic [9:0] x);
        logic [19:0] sq;
        logic [3:0] e;
        logic [19:0] sh;
        sq = 20'(x) * 20'(x);
        e = 4'h0;
        for (int i = 8; i < 20; i++) begin
            if (sq[i]) e = 4'(i - 7);
        end
        sh = sq >> e;
        degamma = {sh[7:0], e};
    endfunction

    function automatic logic signed [12:0] median3(
        input logic signed [12:0] a,
        input logic signed [12:0] b,
        input logic signed [12:0] c);
        if ((a >= b) == (a <= c)) median3 = a;
        else if ((b >= a) == (b <= c)) median3 = b;
        else median3 = c;
    endfunction

    function automatic iph_pix_t sat12(input logic signed [27:0] v);
        if (v < 0) sat12 = 12'h000;
        else if (v > $signed({16'h0000, `IPH_PIX_MAX})) sat12 = `IPH_PIX_MAX;
        else sat12 = v[11:0];
    endfunction

    // ------------------------------------------------------------
    // Sample history and per-channel stages
    // ------------------------------------------------------------
    logic [9:0] pixIn [0:2];
    logic [9:0] tap_ff [0:2][0:4];
    iph_pix_t s1_ff [0:2];
    iph_pix_t s2_ff [0:2];
    iph_pix_t mixed [0:2];
    iph_pix_t yellow_ff;
    iph_pix_t cyan_ff;
    logic valid_ff;

    assign pixIn[0] = pixInRed;
    assign pixIn[1] = pixInGreen;
    assign pixIn[2] = pixInBlue;

    // Taps move only with a real sample, so gaps do not smear edges
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int c = 0; c < 3; c++) begin
                for (int t = 0; t < 5; t++) tap_ff[c][t] <= 10'h000;
            end
        end else if (pixValid) begin
            for (int c = 0; c < 3; c++) begin
                tap_ff[c][0] <= pixIn[c];
                for (int t = 1; t < 5; t++) tap_ff[c][t] <= tap_ff[c][t-1];
            end
        end
    end

    for (genvar c = 0; c < 3; c++) begin : g_chan
        logic signed [12:0] bpHist_ff [0:1];
        logic signed [12:0] bp, med, lim, sum;
        logic [9:0] nearA, nearB, filt;
        iph_pix_t lin;
        logic [31:0] prod;
        logic signed [27:0] acc;
        logic [11:0] coef;

        // Chroma lift on the two colour-difference channels only
        always_comb begin
            nearA = chromaFreqSel ? tap_ff[c][0] : tap_ff[c][1];
            nearB = chromaFreqSel ? tap_ff[c][4] : tap_ff[c][3];
            bp = $signed({2'b00, tap_ff[c][2], 1'b0})
                - $signed({3'b000, nearA}) - $signed({3'b000, nearB});
            med = median3(bp, bpHist_ff[0], bpHist_ff[1]);
            if (med < `IPH_CHROMA_CORE && med > -`IPH_CHROMA_CORE) begin
                lim = 13'sh0000; // Coring
            end else if (med > `IPH_CHROMA_LIMIT) begin
                lim = `IPH_CHROMA_LIMIT;
            end else if (med < -`IPH_CHROMA_LIMIT) begin
                lim = -`IPH_CHROMA_LIMIT;
            end else begin
                lim = med;
            end
            sum = $signed({3'b000, tap_ff[c][2]}) + lim;
            if (!chromaEn || c == 0) filt = tap_ff[c][2];
            else if (sum < 0) filt = 10'h000;
            else if (sum > `IPH_CHROMA_MAX) filt = 10'h3FF;
            else filt = sum[9:0];
        end

        always_ff @(posedge clk) begin
            if (!rst_b) begin
                bpHist_ff[0] <= 13'sh0000;
                bpHist_ff[1] <= 13'sh0000;
            end else if (pixValid) begin
                bpHist_ff[0] <= bp;
                bpHist_ff[1] <= bpHist_ff[0];
            end
        end

        // Decode or pad, then contrast gain as percent over 100
        always_comb begin
            lin = degammaEn ? degamma(filt)
                : {filt, `IPH_PAD_ZERO};
            prod = 32'(lin) * 32'(contrastPct) * `IPH_RECIP_100;
        end

        // Matrix, then brightness bias; identity when adjust is off
        always_comb begin
            acc = 28'sh0000000;
            for (int k = 0; k < 3; k++) begin
                coef = ccaEn ? matrixCoef[(c*3+k)*12 +: 12]
                    : ((c == k) ? `IPH_MATRIX_ONE : 12'h000);
                acc = acc + $signed(coef) * $signed({1'b0, s1_ff[k]});
            end
            mixed[c] = sat12((acc >>> `IPH_MATRIX_FRAC)
                + 28'(signed'(brightBias)));
        end

        always_ff @(posedge clk) begin
            if (!rst_b) begin
                s1_ff[c] <= 12'h000;
                s2_ff[c] <= 12'h000;
            end else if (pixValid) begin
                s1_ff[c] <= (|prod[31:29]) ? `IPH_PIX_MAX : prod[28:17];
                s2_ff[c] <= mixed[c];
            end
        end
    end

    // Secondary colours from the pairs of primaries
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            yellow_ff <= 12'h000;
            cyan_ff <= 12'h000;
            valid_ff <= 1'b0;
        end else begin
            valid_ff <= pixValid;
            if (pixValid) begin
                yellow_ff <= !multiEn ? 12'h000
                    : (mixed[0] < mixed[1] ? mixed[0] : mixed[1]);
                cyan_ff <= !multiEn ? 12'h000
                    : (mixed[1] < mixed[2] ? mixed[1] : mixed[2]);
            end
        end
    end

    assign pixOutValid = valid_ff;
    assign pixOutRed = s2_ff[0];
    assign pixOutGreen = s2_ff[1];
    assign pixOutBlue = s2_ff[2];
    assign pixOutYellow = yellow_ff;
    assign pixOutCyan = cyan_ff;

endmodule

// [hdl/iph_command_handler.sv]
`timescale 1ns/1ps
`include "iph_map.svh"

module iph_command_handler
    import iph_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmdStart,
    input wire logic [7:0] cmdOpcode,
    input wire logic [7:0] cmdDest,
    input wire logic cmdRead,
    input wire logic paramValid,
    input wire iph_byte_t paramByte,
    input wire logic cmdEnd,
    output logic cmdReady,
    output logic cmdError,
    output logic rspValid,
    output iph_byte_t rspByte,
    output logic rspLast,
    input wire logic rspReady,
    input wire logic pwmDriver,
    input wire logic frameSync,
    output logic [15:0] driveRed,
    output logic [15:0] driveGreen,
    output logic [15:0] driveBlue,
    output logic [15:0] driveCustomOne,
    output logic [15:0] driveCustomTwo,
    output logic [15:0] driveSense,
    output iph_byte_t pwmSelect,
    output logic chromaFilterEnable,
    output logic degammaEnable,
    output logic ccaEnable,
    output logic multiPrimaryEnable,
    output logic whitePointEnable,
    output logic adaptiveBlackEnable,
    output logic hdrEnable,
    input wire logic chromaFreqSel,
    input wire logic [107:0] colourMatrixCoef,
    input wire logic pixValid,
    input wire logic [9:0] pixInRed,
    input wire logic [9:0] pixInGreen,
    input wire logic [9:0] pixInBlue,
    output logic pixOutValid,
    output iph_pix_t pixOutRed,
    output iph_pix_t pixOutGreen,
    output iph_pix_t pixOutBlue,
    output iph_pix_t pixOutYellow,
    output iph_pix_t pixOutCyan
);

    // ------------------------------------------------------------
    // Decode helpers
    // ------------------------------------------------------------
    // Parameter byte count each command must carry
    function automatic logic [3:0] lenFor(input logic [7:0] op,
                                          input logic rd);
        unique case (op)
            `IPH_OP_DRIVE: lenFor = rd ? `IPH_LEN_DRIVE_RD
                : `IPH_LEN_DRIVE_WR;
            `IPH_OP_ALG: lenFor = rd ? `IPH_LEN_NONE : `IPH_LEN_ALG;
            `IPH_OP_BRIGHT,
            `IPH_OP_CONTRAST: lenFor = rd ? `IPH_LEN_NONE : `IPH_LEN_WORD;
            default: lenFor = `IPH_LEN_BAD;
        endcase
    endfunction

    // Bytes returned by a read
    function automatic logic [3:0] rspLenFor(input logic [7:0] op);
        unique case (op)
            `IPH_OP_DRIVE: rspLenFor = `IPH_LEN_DRIVE_RSP;
            `IPH_OP_ALG: rspLenFor = `IPH_LEN_ALG;
            default: rspLenFor = `IPH_LEN_WORD;
        endcase
    endfunction

    // ------------------------------------------------------------
    // Command state
    // ------------------------------------------------------------
    iph_state_e state_ff;
    logic [7:0] op_ff;
    logic rd_ff;
    logic destOk_ff;
    logic [3:0] cnt_ff;
    iph_byte_t buf_ff [0:12];
    logic [3:0] rspIdx_ff;
    logic [3:0] rspLen_ff;
    iph_byte_t rspByte_ff;
    logic rspLast_ff;
    logic cmdError_ff;

    logic [15:0] driveLvl_ff [0:5];
    logic [15:0] driveOut_ff [0:5];
    iph_byte_t pwmSel_ff;
    logic [6:0] algSet_ff;
    logic [6:0] algAct_ff;
    logic [10:0] brightSet_ff;
    logic [10:0] brightAct_ff;
    logic [7:0] contrastSet_ff;
    logic [7:0] contrastAct_ff;
    logic [8:0] contrastEff_ff;

    logic [15:0] word01;
    logic [15:0] brightWide;
    logic lenOk, rangeOk, cmdOk, endNow, wrCommit, rdStart, rspStep;
    logic rspLoad;
    logic [3:0] rdIdx;
    iph_byte_t rdByte;
    logic [16:0] thirdUp;

    assign word01 = {buf_ff[1], buf_ff[0]};
    assign brightWide = {{5{brightSet_ff[10]}}, brightSet_ff};
    assign endNow = (state_ff == IPH_COLLECT) && cmdEnd;

    // Destination, length and range checks decide commit or error
    always_comb begin
        lenOk = (cnt_ff == lenFor(op_ff, rd_ff));
        rangeOk = 1'b1;
        if (!rd_ff && op_ff == `IPH_OP_BRIGHT) begin
            rangeOk = ($signed(word01) >= $signed(`IPH_BRIGHT_MIN))
                && ($signed(word01) <= $signed(`IPH_BRIGHT_MAX));
        end else if (!rd_ff && op_ff == `IPH_OP_CONTRAST) begin
            rangeOk = (word01 <= `IPH_CONTRAST_MAX);
        end
        cmdOk = destOk_ff && lenOk && rangeOk;
        wrCommit = endNow && cmdOk && !rd_ff;
        rdStart = endNow && cmdOk && rd_ff;
        rspStep = (state_ff == IPH_RESPOND) && rspReady && !rspLast_ff;
        rspLoad = rdStart || rspStep;
        rdIdx = rdStart ? 4'h0 : 4'(rspIdx_ff + 4'h1);
    end

    // Sequencer: idle, gather parameters, stream the answer
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            state_ff <= IPH_IDLE;
        end else begin
            unique case (state_ff)
                IPH_IDLE: if (cmdStart) state_ff <= IPH_COLLECT;
                IPH_COLLECT: if (cmdEnd) begin
                    state_ff <= rdStart ? IPH_RESPOND : IPH_IDLE;
                end
                IPH_RESPOND: if (rspReady && rspLast_ff) begin
                    state_ff <= IPH_IDLE;
                end
                default: state_ff <= IPH_IDLE;
            endcase
        end
    end

    // Header capture and parameter gathering
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            op_ff <= 8'h00;
            rd_ff <= 1'b0;
            destOk_ff <= 1'b0;
            cnt_ff <= 4'h0;
            for (int i = 0; i < 13; i++) buf_ff[i] <= 8'h00;
        end else if (state_ff == IPH_IDLE && cmdStart) begin
            op_ff <= cmdOpcode;
            rd_ff <= cmdRead;
            destOk_ff <= (cmdDest == `IPH_DEST_IMAGE);
            cnt_ff <= 4'h0;
        end else if (state_ff == IPH_COLLECT && paramValid) begin
            // Bytes past the buffer only bump the count, which stops at 14, so the length check fails
            if (cnt_ff < `IPH_BUF_DEPTH) buf_ff[cnt_ff] <= paramByte;
            if (cnt_ff <= `IPH_BUF_DEPTH) cnt_ff <= cnt_ff + 4'h1;
        end
    end

    // ------------------------------------------------------------
    // Parameter stores
    // ------------------------------------------------------------
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 6; i++) driveLvl_ff[i] <= 16'h0000;
            pwmSel_ff <= 8'h00;
        end else if (wrCommit && op_ff == `IPH_OP_DRIVE) begin
            // Leading byte is kept only for a PWM type driver
            pwmSel_ff <= pwmDriver ? buf_ff[0] : 8'h00;
            for (int i = 0; i < 6; i++) begin
                driveLvl_ff[i] <= {buf_ff[2*i+2], buf_ff[2*i+1]};
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            algSet_ff <= 7'h00;
        end else if (wrCommit && op_ff == `IPH_OP_ALG) begin
            for (int i = 0; i < 7; i++) begin
                algSet_ff[i] <= buf_ff[i][0];
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            brightSet_ff <= 11'h000;
        end else if (wrCommit && op_ff == `IPH_OP_BRIGHT) begin
            brightSet_ff <= word01[10:0];
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            contrastSet_ff <= `IPH_CONTRAST_DEF;
        end else if (wrCommit && op_ff == `IPH_OP_CONTRAST) begin
            contrastSet_ff <= word01[7:0];
        end
    end

    // Datapath copies swap only on a frame boundary, never mid-frame
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            algAct_ff <= 7'h00;
            brightAct_ff <= 11'h000;
            contrastAct_ff <= `IPH_CONTRAST_DEF;
        end else if (frameSync) begin
            algAct_ff <= algSet_ff;
            brightAct_ff <= brightSet_ff;
            contrastAct_ff <= contrastSet_ff;
        end
    end

    // ------------------------------------------------------------
    // Adaptive black: less current, more pixel gain
    // ------------------------------------------------------------
    // A fixed quarter cut; the gain rises by a third to keep light
    assign thirdUp = 17'(contrastAct_ff) * `IPH_THIRD_MUL;

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            for (int i = 0; i < 6; i++) driveOut_ff[i] <= 16'h0000;
            contrastEff_ff <= 9'(`IPH_CONTRAST_DEF);
        end else begin
            for (int i = 0; i < 6; i++) begin
                driveOut_ff[i] <= algAct_ff[`IPH_ALG_BLACK]
                    ? driveLvl_ff[i] - (driveLvl_ff[i] >> 2)
                    : driveLvl_ff[i];
            end
            contrastEff_ff <= algAct_ff[`IPH_ALG_BLACK]
                ? 9'(contrastAct_ff) + 9'(thirdUp >> `IPH_THIRD_SHIFT)
                : 9'(contrastAct_ff);
        end
    end

    // ------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------
    // Same byte layout as the write, minus the leading PWM select byte on drive reads
    always_comb begin
        rdByte = 8'h00;
        unique case (op_ff)
            `IPH_OP_DRIVE: rdByte = rdIdx[0]
                ? driveLvl_ff[rdIdx[3:1]][15:8]
                : driveLvl_ff[rdIdx[3:1]][7:0];
            `IPH_OP_ALG: rdByte = {7'h00, algSet_ff[rdIdx[2:0]]};
            `IPH_OP_BRIGHT: rdByte = rdIdx[0] ? brightWide[15:8]
                : brightWide[7:0];
            `IPH_OP_CONTRAST: rdByte = rdIdx[0] ? 8'h00 : contrastSet_ff;
            default: rdByte = 8'h00;
        endcase
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            rspIdx_ff <= 4'h0;
            rspLen_ff <= 4'h0;
            rspByte_ff <= 8'h00;
            rspLast_ff <= 1'b0;
        end else if (rspLoad) begin
            rspIdx_ff <= rdIdx;
            rspByte_ff <= rdByte;
            if (rdStart) begin
                rspLen_ff <= rspLenFor(op_ff);
                rspLast_ff <= (rspLenFor(op_ff) == 4'h1);
            end else begin
                rspLast_ff <= (4'(rdIdx + 4'h1) == rspLen_ff);
            end
        end
    end

    // Rejected commands flag a one-cycle error and change nothing
    always_ff @(posedge clk) begin
        if (!rst_b) cmdError_ff <= 1'b0;
        else cmdError_ff <= endNow && !cmdOk;
    end

    assign cmdReady = (state_ff == IPH_IDLE);
    assign cmdError = cmdError_ff;
    assign rspValid = (state_ff == IPH_RESPOND);
    assign rspByte = rspByte_ff;
    assign rspLast = rspLast_ff;
    assign driveRed = driveOut_ff[0];
    assign driveGreen = driveOut_ff[1];
    assign driveBlue = driveOut_ff[2];
    assign driveCustomOne = driveOut_ff[3];
    assign driveCustomTwo = driveOut_ff[4];
    assign driveSense = driveOut_ff[5];
    assign pwmSelect = pwmSel_ff;
    assign chromaFilterEnable = algAct_ff[`IPH_ALG_CHROMA];
    assign degammaEnable = algAct_ff[`IPH_ALG_DEGAMMA];
    assign ccaEnable = algAct_ff[`IPH_ALG_CCA];
    assign multiPrimaryEnable = algAct_ff[`IPH_ALG_MULTI];
    assign whitePointEnable = algAct_ff[`IPH_ALG_WHITE];
    assign adaptiveBlackEnable = algAct_ff[`IPH_ALG_BLACK];
    assign hdrEnable = algAct_ff[`IPH_ALG_HDR];

    // ------------------------------------------------------------
    // Image datapath
    // ------------------------------------------------------------
    iph_pixel_path u_path (
        .clk(clk),
        .rst_b(rst_b),
        .pixValid(pixValid),
        .pixInRed(pixInRed),
        .pixInGreen(pixInGreen),
        .pixInBlue(pixInBlue),
        .chromaEn(algAct_ff[`IPH_ALG_CHROMA]),
        .chromaFreqSel(chromaFreqSel),
        .degammaEn(algAct_ff[`IPH_ALG_DEGAMMA]),
        .ccaEn(algAct_ff[`IPH_ALG_CCA]),
        .multiEn(algAct_ff[`IPH_ALG_MULTI]),
        .brightBias(brightAct_ff),
        .contrastPct(contrastEff_ff),
        .matrixCoef(colourMatrixCoef),
        .pixOutValid(pixOutValid),
        .pixOutRed(pixOutRed),
        .pixOutGreen(pixOutGreen),
        .pixOutBlue(pixOutBlue),
        .pixOutYellow(pixOutYellow),
        .pixOutCyan(pixOutCyan)
    );

endmodule

// [test/iph_chk_props.sv]
`timescale 1ns/1ps
// Port checks: command bus timing, frame gating, pixel strobe
module iph_chk
    import iph_pkg::*;
(
    input wire logic clk,
    input wire logic rst_b,
    input wire logic cmdEnd,
    input wire logic cmdError,
    input wire logic cmdReady,
    input wire logic rspValid,
    input wire logic rspReady,
    input wire iph_byte_t rspByte,
    input wire logic rspLast,
    input wire logic frameSync,
    input wire logic degammaEnable,
    input wire logic pixValid,
    input wire logic pixOutValid
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    err_follow_a: assert property (cmdError |-> $past(cmdEnd))
        else $error("error without end");
    err_pulse_a: assert property (cmdError |=> !cmdError)
        else $error("error too long");
    rsp_start_a: assert property ($rose(rspValid) |-> $past(cmdEnd))
        else $error("reply not after end");
    rsp_hold_a: assert property (rspValid && !rspReady |=>
        rspValid && $stable(rspByte) && $stable(rspLast))
        else $error("reply byte moved");
    rsp_busy_a: assert property (rspValid |-> !cmdReady)
        else $error("ready while replying");
    ready_rise_a: assert property ($rose(cmdReady) |->
        $past(cmdEnd) || $past(rspLast) && $past(rspReady))
        else $error("ready without finish");
    flag_frame_a: assert property ($changed(degammaEnable) |->
        $past(frameSync))
        else $error("flag moved off frame");
    pix_strobe_a: assert property (pixOutValid == $past(pixValid))
        else $error("pixel strobe delay");
endmodule
bind iph_command_handler iph_chk chk (.clk(clk), .rst_b(rst_b),
    .cmdEnd(cmdEnd), .cmdError(cmdError), .cmdReady(cmdReady),
    .rspValid(rspValid), .rspReady(rspReady), .rspByte(rspByte),
    .rspLast(rspLast), .frameSync(frameSync),
    .degammaEnable(degammaEnable), .pixValid(pixValid),
    .pixOutValid(pixOutValid));

// [test/iph_host.sv]
`timescale 1ns/1ps
// Host model; ready toggles so each reply byte waits one cycle
module iph_host
    import iph_pkg::*;
(
    input wire logic clk,
    output logic cmdStart,
    output logic [7:0] cmdOpcode,
    output logic [7:0] cmdDest,
    output logic cmdRead,
    output logic paramValid,
    output iph_byte_t paramByte,
    output logic cmdEnd,
    input wire logic cmdError,
    input wire logic rspValid,
    input wire iph_byte_t rspByte,
    input wire logic rspLast,
    output logic rspReady
);
    logic err;
    logic [95:0] r;
    initial {cmdStart, cmdOpcode, cmdDest, cmdRead} = '0;
    initial {paramValid, paramByte, cmdEnd, rspReady} = '0;
    // Header, n bytes low first, then end marker
    task automatic xfer(input logic [7:0] op, d, input logic rd,
                        input int n, input logic [103:0] p);
        int i;
        int k;
        @(posedge clk) #2;
        {cmdStart, cmdOpcode, cmdDest, cmdRead} = {1'b1, op, d, rd};
        for (i = 0; i < n; i++) begin
            @(posedge clk) #2;
            {cmdStart, paramValid, paramByte} = {2'b01, p[8*i+:8]};
        end
        @(posedge clk) #2;
        {cmdStart, paramValid, cmdEnd} = 3'b001;
        @(posedge clk) #2;
        cmdEnd = 0;
        err = cmdError;
        r = '0;
        i = 0;
        for (k = 0; rd && k < 40; k++) begin
            @(posedge clk);
            if (rspValid && rspReady) begin
                r[8*i+:8] = rspByte;
                i++;
                if (rspLast) break;
            end
            #2 rspReady = !rspReady;
        end
        #2 rspReady = 0;
    endtask
endmodule

// [test/testbench.sv]
`timescale 1ns/1ps
module testbench
    import iph_pkg::*;
;
    logic clk, rst_b, cmdStart, cmdRead, paramValid, cmdEnd, cmdReady;
    logic cmdError, rspValid, rspLast, rspReady, pwmDriver, frameSync;
    logic pixValid, pixOutValid, chromaFilterEnable, degammaEnable;
    logic adaptiveBlackEnable;
    logic [7:0] cmdOpcode, cmdDest;
    iph_byte_t paramByte, rspByte, pwmSelect;
    logic [15:0] driveRed;
    logic [9:0] pixInRed, pixInGreen, pixInBlue;
    iph_pix_t pixOutRed, pixOutGreen, pixOutBlue, pixOutYellow, pixOutCyan;
    int failures = 0, testsRun = 0, cyc = 0;
    iph_host h (.clk, .cmdStart, .cmdOpcode, .cmdDest, .cmdRead,
        .paramValid, .paramByte, .cmdEnd, .cmdError, .rspValid, .rspByte,
        .rspLast, .rspReady);
    // Matrix tied to zero: only the forced identity can pass pixels
    iph_command_handler DUT (.clk, .rst_b, .cmdStart, .cmdOpcode,
        .cmdDest, .cmdRead, .paramValid, .paramByte, .cmdEnd, .cmdReady,
        .cmdError, .rspValid, .rspByte, .rspLast, .rspReady, .pwmDriver,
        .frameSync, .driveRed, .driveGreen(), .driveBlue(),
        .driveCustomOne(), .driveCustomTwo(), .driveSense(), .pwmSelect,
        .chromaFilterEnable, .degammaEnable, .ccaEnable(),
        .multiPrimaryEnable(), .whitePointEnable(),
        .adaptiveBlackEnable, .hdrEnable(), .chromaFreqSel(1'b0),
        .colourMatrixCoef(108'h0), .pixValid, .pixInRed, .pixInGreen,
        .pixInBlue, .pixOutValid, .pixOutRed, .pixOutGreen, .pixOutBlue,
        .pixOutYellow, .pixOutCyan);
    task automatic chk(input logic [95:0] g, e);
        testsRun++;
        if (g !== e) begin
            failures++;
            $display("[ERR] %0t got %0h exp %0h", $time, g, e);
        end
    endtask
    task automatic give_verdict;
        $display("compares %0d mismatches %0d", testsRun, failures);
        if (failures == 0 && testsRun > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        clk = 0;
        forever #12.5 clk = ~clk;
    end
    // Hang guard, well above the roughly 190 cycles needed
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 2000) begin
            failures++;
            give_verdict;
        end
    end
    initial begin
        {rst_b, pwmDriver, frameSync, pixValid} = '0;
        {pixInRed, pixInGreen, pixInBlue} = {10'h3FF, 10'h155, 10'h001};
        repeat (20) @(posedge clk);
        #2 rst_b = 1;
        // Defaults: pad only, identity matrix, no secondaries
        repeat (12) @(posedge clk) #2 pixValid = !pixValid;
        chk({pixOutRed, pixOutGreen, pixOutBlue, pixOutYellow, pixOutCyan},
            60'hFFC554004000000);
        $display("pixel test done");
        h.xfer(8'h42, 8'h04, 1, 0, 0);
        chk(h.r, 96'h64);
        h.xfer(8'h42, 8'h04, 0, 2, 16'h00C8);
        h.xfer(8'h42, 8'h04, 0, 2, 16'h00C9);
        chk(h.err, 1);
        h.xfer(8'h42, 8'h05, 0, 2, 16'h0001);
        chk(h.err, 1);
        h.xfer(8'h42, 8'h04, 1, 0, 0);
        chk(h.r, 96'hC8);
        h.xfer(8'h41, 8'h04, 0, 2, 16'hFC00);
        chk(h.err, 0);
        h.xfer(8'h41, 8'h04, 0, 2, 16'h0400);
        chk(h.err, 1);
        h.xfer(8'h41, 8'h04, 1, 0, 0);
        chk(h.r, 96'hFC00);
        $display("level test done");
        // Only bit 0 counts; nothing moves before the frame edge
        h.xfer(8'h40, 8'h04, 0, 7, 56'h000000FEFFFFFF);
        chk({chromaFilterEnable, degammaEnable}, 0);
        @(posedge clk) #2 frameSync = 1;
        @(posedge clk) #2 frameSync = 0;
        chk({chromaFilterEnable, degammaEnable}, 2'h3);
        h.xfer(8'h40, 8'h04, 1, 0, 0);
        chk(h.r, 96'h010101);
        $display("flag test done");
        pwmDriver = 1;
        h.xfer(8'h8C, 8'h04, 0, 13,
            {96'h000600050004000300021234, 8'h5A});
        @(posedge clk) #2;
        chk({driveRed, pwmSelect}, 24'h12345A);
        h.xfer(8'h8C, 8'h04, 1, 1, 0);
        chk(h.r, 96'h000600050004000300021234);
        pwmDriver = 0;
        h.xfer(8'h8C, 8'h04, 0, 13, {96'h1234, 8'h5A});
        @(posedge clk) #2;
        chk({driveRed, pwmSelect}, 24'h123400);
        h.xfer(8'h40, 8'h04, 0, 7, 56'h00010000000000);
        repeat (2) @(posedge clk) #2 frameSync = !frameSync;
        @(posedge clk) #2;
        chk({driveRed, adaptiveBlackEnable}, 17'h1B4F);
        repeat (6) @(posedge clk) #2 pixValid = !pixValid;
        chk({pixOutRed, pixOutGreen, pixOutBlue},
            36'hBFFA2D000);
        $display("drive test done");
        give_verdict;
    end
endmodule
